// >>> rtl/pocm_pkg.sv
// Purpose: constants for the phase octant and multiplexer control
// Assumes: 125 MHz core clock
// Notes:   times in ns, cycle counts derived and rounded
package pocm_pkg;
	localparam int unsigned CLK_PS = 8000;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	localparam logic [7:0] OFF_CNT  = 8'h08;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	// control word field positions
	localparam int unsigned B_ENABLE = 15;
	localparam int unsigned B_ANT    = 14;
	localparam int unsigned B_RFCAL  = 13;
	localparam int unsigned B_IFCAL  = 12;
	localparam int unsigned B_CSEL1  = 11;
	localparam int unsigned B_CSEL2  = 10;
	localparam int unsigned B_WIDE   = 9;
	// times as printed, in ns
	localparam int unsigned SETTLE_NS = 1000;
	localparam int unsigned DEAD_NS   = 1100;
	localparam int unsigned NARROW_NS = 700;
	localparam int unsigned WIDE_NS   = 5000;
	localparam int unsigned CONV_NS   = 2133;
	// least times round up
	localparam int unsigned SETTLE_CYC =
		(SETTLE_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int unsigned DEAD_CYC =
		(DEAD_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int unsigned NARROW_CYC =
		(NARROW_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int unsigned WIDE_CYC =
		(WIDE_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int unsigned CONV_CYC =
		(CONV_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int unsigned TMR_W = 10;
	// series switch positions
	localparam int unsigned SW_AMP   = 0;
	localparam int unsigned SW_FREQ  = 1;
	localparam int unsigned SW_SIN_A = 2;
	localparam int unsigned SW_COS_A = 3;
	localparam int unsigned SW_SIN_B = 4;
	localparam int unsigned SW_COS_B = 5;
	localparam int unsigned SW_CSIN  = 6;
	localparam int unsigned SW_CCOS  = 7;
	localparam int unsigned NUM_SW   = 8;
	typedef enum logic [1:0] {
		MODE_NORMAL,
		MODE_RFCAL,
		MODE_IFCAL
	} pocm_mode_type;
endpackage

// >>> rtl/pocm_sync.sv
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to core_clk_i
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
module pocm_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             core_clk_i,
	input  wire logic             rstn_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge core_clk_i)
	begin
		if (!rstn_i)
		begin
			meta   <= '0;
			sync_o <= '0;
		end
		else
		begin
			meta   <= async_i;
			sync_o <= meta;
		end
	end
endmodule // pocm_sync

// >>> rtl/pocm_octant.sv
// Purpose: octant decode and sine or cosine choice for one channel
// Assumes: comparator levels already synchronised
// Notes:   all outputs registered on the capture strobe
`timescale 1ns/1ps
module pocm_octant (
	input  wire logic       core_clk_i,
	input  wire logic       rstn_i,
	input  wire logic       capture_i,
	input  wire logic       sine_pos_i,
	input  wire logic       cosine_pos_i,
	input  wire logic       sine_gt_cos_i,
	input  wire logic       cos_gt_sine_i,
	output logic      [2:0] octant_o,
	output logic            select_sine_o,
	output logic            select_cosine_o
);
	logic bit1;

	// same polarity gives one
	assign bit1 = ~(sine_pos_i ^ cosine_pos_i); // R10

	always_ff @(posedge core_clk_i)
	begin
		if (!rstn_i)
		begin
			octant_o        <= 3'h0;
			select_sine_o   <= 1'b0;
			select_cosine_o <= 1'b0;
		end
		else if (capture_i) // R7
		begin
			octant_o[2]     <= sine_pos_i; // R9
			octant_o[1]     <= bit1;
			octant_o[0]     <= ~(sine_gt_cos_i ^ bit1); // R11
			select_sine_o   <= cos_gt_sine_i; // R8
			select_cosine_o <= ~cos_gt_sine_i; // R8
		end
	end
endmodule // pocm_octant

// >>> rtl/pocm_top.sv
// Purpose: control part of the pulse conversion unit
// Assumes: APB slave, zero wait states; comparator pins asynchronous
// Notes:   octant bits, multiplexer sequencing, pulse width reject
//
// Functional notes
// R1 - bit 15 enables pulse processing
// R2 - bit 14 selects antenna one or two
// R3 - bit 13 low selects RF calibration
// R4 - bit 12 high selects IF calibration
// R5 - bits 11:10 pick IF calibration phase
// R6 - bit 9 picks narrow or wide hold
// R7 - capture comparators on sector strobe after settle
// R8 - convert smaller of sine or cosine
// R9 - octant bit one follows sine polarity
// R10 - octant bit two is polarity xnor
// R11 - octant bit three compares magnitude, bit two
// R12 - channel B decoded like channel A
// R13 - 1.1 us dead time between conversions
// R14 - shunt switch closed when none active
// R15 - conversion order depends on mode
// R16 - octant bits head each phase word
// R17 - reject pulses shorter than 0.7/5 us
// R18 - control word held until rewritten
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
module pocm_top (
	input  wire logic        core_clk_i,
	input  wire logic        rstn_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        pulse_video_i,
	input  wire logic        sine_a_polarity_i,
	input  wire logic        cosine_a_polarity_i,
	input  wire logic        sine_gt_cos_a_i,
	input  wire logic        cos_gt_sine_a_i,
	input  wire logic        sine_b_polarity_i,
	input  wire logic        cosine_b_polarity_i,
	input  wire logic        sine_gt_cos_b_i,
	input  wire logic        cos_gt_sine_b_i,
	output logic             antenna_two_o,
	output logic             rf_cal_mode_o,
	output logic             if_cal_mode_o,
	output logic      [1:0]  if_cal_phase_o,
	output logic             wide_pulse_o,
	output logic             hold_gate_o,
	output logic             sector_capture_strobe_o,
	output logic      [7:0]  series_switch_o,
	output logic             shunt_switch_o,
	output logic             adc_load_o,
	output logic      [2:0]  conv_index_o,
	output logic      [2:0]  phase_a_msb_o,
	output logic      [2:0]  phase_b_msb_o,
	output logic             select_sine_chan_a_o,
	output logic             select_cosine_chan_a_o,
	output logic             select_sine_chan_b_o,
	output logic             select_cosine_chan_b_o
);
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_QUAL,
		ST_SETTLE,
		ST_CAPTURE,
		ST_CONV,
		ST_DEAD,
		ST_WAIT_LOW
	} pocm_state_type;

	localparam logic [pocm_pkg::TMR_W-1:0] SETTLE_T =
		pocm_pkg::TMR_W'(pocm_pkg::SETTLE_CYC - 1);
	localparam logic [pocm_pkg::TMR_W-1:0] DEAD_T =
		pocm_pkg::TMR_W'(pocm_pkg::DEAD_CYC - 1);
	localparam logic [pocm_pkg::TMR_W-1:0] CONV_T =
		pocm_pkg::TMR_W'(pocm_pkg::CONV_CYC - 1);
	localparam logic [pocm_pkg::TMR_W-1:0] NARROW_T =
		pocm_pkg::TMR_W'(pocm_pkg::NARROW_CYC - 1);
	localparam logic [pocm_pkg::TMR_W-1:0] WIDE_T =
		pocm_pkg::TMR_W'(pocm_pkg::WIDE_CYC - 1);

	logic [15:0]                 mode_control_word;
	logic [15:0]                 pulse_count;
	logic [15:0]                 reject_count;
	pocm_state_type              state;
	logic [pocm_pkg::TMR_W-1:0]  timer;
	logic [2:0]                  conv_index;
	logic [8:0]                  pin_sync;
	logic                        pulse_s;
	logic                        capture;
	logic                        timer_done;
	logic                        last_conv;
	logic [pocm_pkg::TMR_W-1:0]  min_width;
	logic [2:0]                  conv_count;
	logic [7:0]                  next_switch;
	pocm_pkg::pocm_mode_type     mode;
	logic                        wr_en;
	logic                        rd_en;
	logic                        mapped;
	logic [31:0]                 next_rdata;

	pocm_sync #(
		.WIDTH (9)
	) u_sync (
		.core_clk_i (core_clk_i),
		.rstn_i     (rstn_i),
		.async_i    ({pulse_video_i,
			sine_a_polarity_i, cosine_a_polarity_i,
			sine_gt_cos_a_i, cos_gt_sine_a_i,
			sine_b_polarity_i, cosine_b_polarity_i,
			sine_gt_cos_b_i, cos_gt_sine_b_i}),
		.sync_o     (pin_sync)
	);

	assign pulse_s = pin_sync[8];
	assign capture = (state == ST_CAPTURE);

	pocm_octant u_oct_a (
		.core_clk_i      (core_clk_i),
		.rstn_i          (rstn_i),
		.capture_i       (capture),
		.sine_pos_i      (pin_sync[7]),
		.cosine_pos_i    (pin_sync[6]),
		.sine_gt_cos_i   (pin_sync[5]),
		.cos_gt_sine_i   (pin_sync[4]),
		.octant_o        (phase_a_msb_o), // R16
		.select_sine_o   (select_sine_chan_a_o),
		.select_cosine_o (select_cosine_chan_a_o)
	);

	// channel B uses the same decoder
	pocm_octant u_oct_b ( // R12
		.core_clk_i      (core_clk_i),
		.rstn_i          (rstn_i),
		.capture_i       (capture),
		.sine_pos_i      (pin_sync[3]),
		.cosine_pos_i    (pin_sync[2]),
		.sine_gt_cos_i   (pin_sync[1]),
		.cos_gt_sine_i   (pin_sync[0]),
		.octant_o        (phase_b_msb_o), // R16
		.select_sine_o   (select_sine_chan_b_o),
		.select_cosine_o (select_cosine_chan_b_o)
	);

	// apb access, no wait states
	assign pready_o = 1'b1;
	assign wr_en    = psel_i & penable_i & pwrite_i;
	assign rd_en    = psel_i & penable_i & ~pwrite_i;
	assign mapped   = (paddr_i == pocm_pkg::OFF_CTRL) |
		(paddr_i == pocm_pkg::OFF_STAT) |
		(paddr_i == pocm_pkg::OFF_CNT);
	assign pslverr_o = psel_i & penable_i & ~mapped;

	always_ff @(posedge core_clk_i)
	begin
		if (!rstn_i)
			mode_control_word <= pocm_pkg::CTRL_RST;
		else if (wr_en && paddr_i == pocm_pkg::OFF_CTRL)
			mode_control_word <= pwdata_i[15:0]; // R18
	end

	always_comb
	begin
		next_rdata = 32'h0000_0000;
		if (paddr_i == pocm_pkg::OFF_CTRL)
			next_rdata = {16'h0000, mode_control_word};
		else if (paddr_i == pocm_pkg::OFF_STAT)
			next_rdata = {16'h0000, state != ST_IDLE,
				conv_index, 2'h0,
				select_sine_chan_b_o, select_sine_chan_a_o,
				2'h0, phase_b_msb_o, phase_a_msb_o};
		else if (paddr_i == pocm_pkg::OFF_CNT)
			next_rdata = {reject_count, pulse_count};
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rstn_i)
			prdata_o <= 32'h0000_0000;
		else if (psel_i && !penable_i && !pwrite_i)
			prdata_o <= next_rdata;
	end

	// decoded control outputs
	always_ff @(posedge core_clk_i)
	begin
		if (!rstn_i)
		begin
			antenna_two_o  <= 1'b0;
			rf_cal_mode_o  <= 1'b0;
			if_cal_mode_o  <= 1'b0;
			if_cal_phase_o <= 2'h0;
			wide_pulse_o   <= 1'b0;
		end
		else
		begin
			antenna_two_o  <= mode_control_word[pocm_pkg::B_ANT]; // R2
			rf_cal_mode_o  <= ~mode_control_word[pocm_pkg::B_RFCAL]; // R3
			if_cal_mode_o  <= mode_control_word[pocm_pkg::B_IFCAL]; // R4
			if_cal_phase_o <= {mode_control_word[pocm_pkg::B_CSEL1],
				mode_control_word[pocm_pkg::B_CSEL2]}; // R5
			wide_pulse_o   <= mode_control_word[pocm_pkg::B_WIDE]; // R6
		end
	end

	// IF calibration takes priority over RF calibration
	always_comb
	begin
		if (mode_control_word[pocm_pkg::B_IFCAL])
			mode = pocm_pkg::MODE_IFCAL; // R4
		else if (!mode_control_word[pocm_pkg::B_RFCAL])
			mode = pocm_pkg::MODE_RFCAL; // R3
		else
			mode = pocm_pkg::MODE_NORMAL;
	end

	assign min_width = mode_control_word[pocm_pkg::B_WIDE] ?
		WIDE_T : NARROW_T; // R6 R17
	assign conv_count = (mode == pocm_pkg::MODE_NORMAL) ?
		3'h5 : 3'h4; // R15
	assign last_conv  = (conv_index == conv_count - 3'h1);
	assign timer_done = (timer == '0);

	// switch for the current conversion slot
	always_comb
	begin
		next_switch = 8'h00;
		if (mode == pocm_pkg::MODE_IFCAL)
		begin
			unique case (conv_index) // R15
				3'h0: next_switch[pocm_pkg::SW_SIN_A] = 1'b1;
				3'h1: next_switch[pocm_pkg::SW_COS_A] = 1'b1;
				3'h2: next_switch[pocm_pkg::SW_SIN_B] = 1'b1;
				3'h3: next_switch[pocm_pkg::SW_COS_B] = 1'b1;
				default: next_switch = 8'h00;
			endcase
		end
		else
		begin
			unique case (conv_index) // R15
				3'h0: next_switch[pocm_pkg::SW_AMP] = 1'b1;
				3'h1: next_switch[pocm_pkg::SW_FREQ] = 1'b1;
				3'h2:
				begin
					next_switch[pocm_pkg::SW_SIN_A] =
						select_sine_chan_a_o; // R8
					next_switch[pocm_pkg::SW_COS_A] =
						select_cosine_chan_a_o;
				end
				3'h3:
				begin
					next_switch[pocm_pkg::SW_SIN_B] =
						select_sine_chan_b_o; // R8
					next_switch[pocm_pkg::SW_COS_B] =
						select_cosine_chan_b_o;
				end
				3'h4:
				begin
					next_switch[pocm_pkg::SW_CSIN] =
						select_sine_chan_a_o;
					next_switch[pocm_pkg::SW_CCOS] =
						select_cosine_chan_a_o;
				end
				default: next_switch = 8'h00;
			endcase
		end
	end

	// process cycle sequencer
	always_ff @(posedge core_clk_i)
	begin
		if (!rstn_i)
		begin
			state      <= ST_IDLE;
			timer      <= '0;
			conv_index <= 3'h0;
		end
		else
		begin
			unique case (state)
				ST_IDLE:
				begin
					conv_index <= 3'h0;
					timer      <= min_width;
					if (pulse_s && mode_control_word[pocm_pkg::B_ENABLE])
						state <= ST_QUAL; // R1
				end
				ST_QUAL:
				begin
					if (!pulse_s)
						state <= ST_IDLE; // R17
					else if (timer_done)
					begin
						state <= ST_SETTLE;
						timer <= SETTLE_T;
					end
					else
						timer <= timer - 1'b1;
				end
				ST_SETTLE:
				begin
					if (timer_done)
						state <= ST_CAPTURE; // R7
					else
						timer <= timer - 1'b1;
				end
				ST_CAPTURE:
				begin
					state <= ST_CONV;
					timer <= CONV_T;
				end
				ST_CONV:
				begin
					if (timer_done)
					begin
						state <= ST_DEAD;
						timer <= DEAD_T; // R13
					end
					else
						timer <= timer - 1'b1;
				end
				ST_DEAD:
				begin
					if (!timer_done)
						timer <= timer - 1'b1;
					else if (last_conv)
						state <= ST_WAIT_LOW;
					else
					begin
						state      <= ST_CONV; // R13
						timer      <= CONV_T;
						conv_index <= conv_index + 3'h1;
					end
				end
				ST_WAIT_LOW:
				begin
					if (!pulse_s)
						state <= ST_IDLE;
				end
			endcase
		end
	end

	// registered multiplexer and timing outputs
	always_ff @(posedge core_clk_i)
	begin
		if (!rstn_i)
		begin
			series_switch_o         <= 8'h00;
			shunt_switch_o          <= 1'b1;
			hold_gate_o             <= 1'b0;
			sector_capture_strobe_o <= 1'b0;
			adc_load_o              <= 1'b0;
			conv_index_o            <= 3'h0;
		end
		else
		begin
			if (state == ST_CONV && !timer_done)
			begin
				series_switch_o <= next_switch;
				shunt_switch_o  <= ~(|next_switch); // R14
			end
			else
			begin
				series_switch_o <= 8'h00;
				shunt_switch_o  <= 1'b1; // R14
			end
			hold_gate_o <= (state == ST_SETTLE) ||
				(state == ST_CAPTURE) || (state == ST_CONV) ||
				(state == ST_DEAD);
			sector_capture_strobe_o <= capture; // R7
			adc_load_o   <= (state == ST_CONV) && timer_done;
			conv_index_o <= conv_index;
		end
	end

	// accepted and rejected pulse counters
	always_ff @(posedge core_clk_i)
	begin
		if (!rstn_i)
		begin
			pulse_count  <= 16'h0000;
			reject_count <= 16'h0000;
		end
		else if (state == ST_QUAL)
		begin
			if (!pulse_s)
				reject_count <= reject_count + 16'h0001; // R17
			else if (timer_done)
				pulse_count <= pulse_count + 16'h0001;
		end
	end
endmodule // pocm_top

// >>> verification/pocm_chk_asserts.sv
// Purpose: port assertions for the octant and multiplexer control
// Assumes: comparator pins held steady while a process cycle runs
// Notes:   bound into pocm_top below the module
`timescale 1ns/1ps
module pocm_chk (
	input  wire logic        core_clk_i,
	input  wire logic        rstn_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic        pulse_video_i,
	input  wire logic        sine_a_polarity_i,
	input  wire logic        cosine_a_polarity_i,
	input  wire logic        sine_gt_cos_a_i,
	input  wire logic        cos_gt_sine_a_i,
	input  wire logic        sine_b_polarity_i,
	input  wire logic        cosine_b_polarity_i,
	input  wire logic        sine_gt_cos_b_i,
	input  wire logic        antenna_two_o,
	input  wire logic        rf_cal_mode_o,
	input  wire logic        if_cal_mode_o,
	input  wire logic [1:0]  if_cal_phase_o,
	input  wire logic        wide_pulse_o,
	input  wire logic        hold_gate_o,
	input  wire logic        sector_capture_strobe_o,
	input  wire logic [7:0]  series_switch_o,
	input  wire logic        shunt_switch_o,
	input  wire logic [2:0]  phase_a_msb_o,
	input  wire logic [2:0]  phase_b_msb_o,
	input  wire logic        select_sine_chan_a_o,
	input  wire logic        select_cosine_chan_a_o
);
	logic [9:0] held_cnt;
	logic [9:0] high_cnt;
	logic       same_a;
	logic       same_b;
	assign same_a = sine_a_polarity_i ~^ cosine_a_polarity_i;
	assign same_b = sine_b_polarity_i ~^ cosine_b_polarity_i;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	// cycles since hold gate rose, and since the pulse pin rose
	always_ff @(posedge core_clk_i)
	begin
		if (!rstn_i || !hold_gate_o)
			held_cnt <= 10'h000;
		else if (held_cnt != 10'h3FF)
			held_cnt <= held_cnt + 10'h001;
	end
	always_ff @(posedge core_clk_i)
	begin
		if (!rstn_i || !pulse_video_i)
			high_cnt <= 10'h000;
		else if (high_cnt != 10'h3FF)
			high_cnt <= high_cnt + 10'h001;
	end
	shunt_idle_a:
	assert property (shunt_switch_o == (series_switch_o == 8'h00))
		else $error("shunt and series switches disagree");
	one_switch_a:
	assert property ($onehot0(series_switch_o))
		else $error("two series switches on");
	dead_time_a:
	assert property ($fell(|series_switch_o) |->
		(series_switch_o == 8'h00)[*8])
		else $error("dead time too short");
	settle_time_a:
	assert property (sector_capture_strobe_o |->
		{22'h0, held_cnt} >= pocm_pkg::SETTLE_CYC)
		else $error("capture before settle time");
	width_qual_a:
	assert property ($rose(hold_gate_o) |-> {22'h0, high_cnt} >=
		(wide_pulse_o ? pocm_pkg::WIDE_CYC : pocm_pkg::NARROW_CYC))
		else $error("short pulse accepted");
	ctrl_write_a:
	assert property (psel_i && penable_i && pwrite_i && paddr_i == 8'h00
		|-> ##2 {antenna_two_o, rf_cal_mode_o, if_cal_mode_o,
		if_cal_phase_o, wide_pulse_o} == ($past(pwdata_i[14:9], 2) ^ 6'h10))
		else $error("mode outputs do not follow control word");
	octant_a_a:
	assert property (sector_capture_strobe_o |-> phase_a_msb_o ==
		{sine_a_polarity_i, same_a, sine_gt_cos_a_i ~^ same_a})
		else $error("channel a octant wrong");
	octant_b_a:
	assert property (sector_capture_strobe_o |-> phase_b_msb_o ==
		{sine_b_polarity_i, same_b, sine_gt_cos_b_i ~^ same_b})
		else $error("channel b octant wrong");
	select_a_a:
	assert property (sector_capture_strobe_o |->
		select_sine_chan_a_o == cos_gt_sine_a_i &&
		select_cosine_chan_a_o != cos_gt_sine_a_i)
		else $error("channel a sine or cosine choice wrong");
endmodule // pocm_chk
bind pocm_top pocm_chk i_pocm_chk (.*);

// >>> verification/pocm_host.sv
// Purpose: host computer model, APB master for control words
// Assumes: slave may stretch the access phase
// Notes:   the bench calls xfer by hierarchical name
`timescale 1ns/1ps
module pocm_host (
	input  wire logic        core_clk_i,
	input  wire logic [31:0] prdata_i,
	input  wire logic        pready_i,
	input  wire logic        pslverr_i,
	output logic             psel_o,
	output logic             penable_o,
	output logic             pwrite_o,
	output logic      [7:0]  paddr_o,
	output logic      [31:0] pwdata_o
);
	initial
	begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 8'h00;
		pwdata_o = 32'h0;
	end
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge core_clk_i);
		psel_o <= 1'b1;
		penable_o <= 1'b0;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge core_clk_i);
		penable_o <= 1'b1;
		do
			@(posedge core_clk_i);
		while (pready_i !== 1'b1);
		q = prdata_i;
		e = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
	endtask
endmodule // pocm_host

// >>> verification/tb_top.sv
// Purpose: self-checking bench for the octant and multiplexer control
// Assumes: host model drives the register bus
// Notes:   mode rows in a table, process cycles hand-written
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {
		logic [15:0] word;
		logic [5:0]  outs;
	} pocm_row_type;
	logic        core_clk_i, rstn_i, psel_i, penable_i, pwrite_i;
	logic [7:0]  paddr_i, series_switch_o;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic        pready_o, pslverr_o, pulse_video_i, err;
	logic        sine_a_polarity_i, cosine_a_polarity_i;
	logic        sine_gt_cos_a_i, cos_gt_sine_a_i;
	logic        sine_b_polarity_i, cosine_b_polarity_i;
	logic        sine_gt_cos_b_i, cos_gt_sine_b_i;
	logic        antenna_two_o, rf_cal_mode_o, if_cal_mode_o;
	logic [1:0]  if_cal_phase_o;
	logic        wide_pulse_o, hold_gate_o, sector_capture_strobe_o;
	logic        shunt_switch_o, adc_load_o;
	logic [2:0]  conv_index_o, phase_a_msb_o, phase_b_msb_o;
	logic        select_sine_chan_a_o, select_cosine_chan_a_o;
	logic        select_sine_chan_b_o, select_cosine_chan_b_o;
	logic [7:0]  last_sw = 8'h00;
	logic [7:0]  seen[$];
	int          mismatches, compares, cycles, loads;
	pocm_row_type rows [5] = '{'{16'h0000, 6'h10}, '{16'h6000, 6'h20},
		'{16'h1C00, 6'h1E}, '{16'h2A00, 6'h05}, '{16'h2400, 6'h02}};
	pocm_top i_pocm_top (.*);
	pocm_host i_pocm_host (.core_clk_i(core_clk_i), .prdata_i(prdata_o),
		.pready_i(pready_o), .pslverr_i(pslverr_o), .psel_o(psel_i),
		.penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i),
		.pwdata_o(pwdata_i));
	initial
	begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge core_clk_i)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			mismatches++;
			wrap_up();
		end
	end
	// record each series switch as it closes
	always @(negedge core_clk_i)
	begin
		if (series_switch_o !== last_sw && series_switch_o !== 8'h00)
		begin
			chk(conv_index_o, seen.size());
			seen.push_back(series_switch_o);
		end
		if (adc_load_o === 1'b1)
			loads++;
		last_sw = series_switch_o;
	end
	task automatic do_reset;
		@(posedge core_clk_i);
		rstn_i <= 1'b0;
		repeat (10) @(posedge core_clk_i);
		@(negedge core_clk_i);
		chk({shunt_switch_o, series_switch_o, pready_o, hold_gate_o}, 11'h402);
		@(posedge core_clk_i);
		rstn_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		@(negedge core_clk_i);
		chk(rf_cal_mode_o, 1'b1);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		i_pocm_host.xfer(1'b1, a, {16'h0, d}, rd, err);
	endtask
	// pulse of len cycles, then the switch order seen against exp
	task automatic run(input int len, input int n, input logic [39:0] exp);
		int i;
		seen.delete();
		loads = 0;
		@(posedge core_clk_i);
		pulse_video_i <= 1'b1;
		repeat (len) @(posedge core_clk_i);
		pulse_video_i <= 1'b0;
		repeat (4) @(negedge core_clk_i);
		for (i = 0; i < 4000 && hold_gate_o !== 1'b0; i++)
			@(negedge core_clk_i);
		chk(seen.size(), n);
		chk(loads, n);
		for (i = 0; i < n && i < seen.size(); i++)
			chk(seen[i], exp[8*i +: 8]);
	endtask
	initial
	begin
		rstn_i = 1'b0;
		pulse_video_i = 1'b0;
		{sine_a_polarity_i, cosine_a_polarity_i, sine_gt_cos_a_i,
			cos_gt_sine_a_i, sine_b_polarity_i, cosine_b_polarity_i,
			sine_gt_cos_b_i, cos_gt_sine_b_i} = 8'h92;
		do_reset();
		foreach (rows[k])
		begin
			wr(8'h00, rows[k].word);
			repeat (2) @(posedge core_clk_i);
			@(negedge core_clk_i);
			chk({antenna_two_o, rf_cal_mode_o, if_cal_mode_o,
				if_cal_phase_o, wide_pulse_o}, rows[k].outs);
		end
		wr(8'h0C, 16'hFFFF);
		chk(err, 1'b1);
		i_pocm_host.xfer(1'b0, 8'h0C, 32'h0, rd, err);
		chk({err, rd[30:0]}, 32'h80000000);
		chk({antenna_two_o, if_cal_phase_o}, 3'h1);
		i_pocm_host.xfer(1'b0, 8'h00, 32'h0, rd, err);
		chk(rd, 32'h0000_2400);
		wr(8'h00, 16'h2000);
		run(200, 0, 40'h0);
		wr(8'h00, 16'hA000);
		run(40, 0, 40'h0);
		run(200, 5, 40'h4020040201);
		chk({phase_a_msb_o, phase_b_msb_o, select_sine_chan_a_o,
			select_cosine_chan_a_o, select_sine_chan_b_o,
			select_cosine_chan_b_o}, 10'h2B9);
		i_pocm_host.xfer(1'b0, 8'h04, 32'h0, rd, err);
		chk(rd, 32'h0000_011D);
		@(posedge core_clk_i);
		{sine_a_polarity_i, cosine_a_polarity_i, sine_gt_cos_a_i,
			cos_gt_sine_a_i} <= 4'h6;
		wr(8'h00, 16'h8000);
		run(200, 4, 40'h0020080201);
		chk({phase_a_msb_o, select_sine_chan_a_o}, 4'h0);
		wr(8'h00, 16'hB000);
		run(200, 4, 40'h0020100804);
		wr(8'h00, 16'hA200);
		run(300, 0, 40'h0);
		run(700, 5, 40'h8020080201);
		i_pocm_host.xfer(1'b0, 8'h08, 32'h0, rd, err);
		chk(rd, 32'h0002_0004);
		do_reset();
		wrap_up();
	end
endmodule // tb_top
